// ==== verilog/imcab_pkg.sv ====
// Package for the interrupt mask clear and communication area base block.
// Assumes a 32-bit operational register window addressed by byte offset.
package imcab_pkg;
    localparam logic [7:0]  IMCAB_OFS_MASK_SET   = 8'h10;
    localparam logic [7:0]  IMCAB_OFS_MASK_CLEAR = 8'h14;
    localparam logic [7:0]  IMCAB_OFS_COMM_BASE  = 8'h18;
    localparam int          IMCAB_BIT_GLOBAL     = 31;
    localparam int          IMCAB_BIT_OWNER      = 30;
    localparam int          IMCAB_BIT_ROOT_PORT  = 6;
    localparam int          IMCAB_BIT_FRAME_WRAP = 5;
    localparam int          IMCAB_BIT_FATAL      = 4;
    localparam int          IMCAB_BIT_WAKEUP     = 3;
    localparam int          IMCAB_BIT_FRAME_ST   = 2;
    localparam int          IMCAB_BIT_WRITEBACK  = 1;
    localparam int          IMCAB_BIT_OVERRUN    = 0;
    // Implemented enable bits: 31, 30, 6..0
    localparam logic [31:0] IMCAB_MASK_DEFINED   = 32'hC000_007F;
    // Base address keeps bits 31..8; low eight read zero
    localparam logic [31:0] IMCAB_MASK_BASE      = 32'hFFFF_FF00;
    localparam logic [31:0] IMCAB_RST_MASK       = 32'h0000_0000;
    localparam logic [31:0] IMCAB_RST_BASE       = 32'h0000_0000;
endpackage

// ==== verilog/imcab_regs.sv ====
// Interrupt enable set/clear pair and communication area base register.
// Assumes a single-cycle register port from the host window; read data is registered.
//
// Function
// (RQ1) Writing 1 to a mask-clear bit clears the matching enable bit.
// (RQ2) Writing 0 to a mask-clear bit leaves the enable bit unchanged.
// (RQ3) Reading the mask-clear register returns the live enable register.
// (RQ4) Each clear bit maps to the enable and status bit of the same position.
// (RQ5) The mask-clear register is one 32-bit word at byte offset 14h.
// (RQ6) Bit 31 is the global enable; clearing it stops all event interrupts.
// (RQ7) Bit 30 enables the ownership-change interrupt.
// (RQ8) Bits 6..0 are the per-event enables and bits 29..7 are reserved.
// (RQ9) After hardware or software reset interrupts are disabled.
// (RQ10) The base register sits at offset 18h and is writable in bits 31..8.
// (RQ11) The base register holds the physical base of the shared area.
// (RQ12) Base bits 7..0 always read zero, giving 256-byte alignment.
// (RQ13) The driver probes alignment by writing ones and counting low zeros.
// (RQ14) The controller fetches its structures from the area at the base.
// (RQ15) An interrupt is requested only for status, enable and global enable all set.
// (RQ16) Writing 1 to an enable bit sets it; writing 0 leaves it.
// (RQ17) Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
module imcab_regs (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        soft_reset_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    // Interrupt path
    input  wire logic [31:0] interrupt_event_flags_in,
    output logic             irq_request_out,
    output logic      [31:0] interrupt_mask_register_out,
    // Shared area base for fetch logic
    output logic      [31:0] comm_area_base_out
);

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] base;
        logic [31:0] rdata;
        logic        irq;
    } imcab_state_t;

    imcab_state_t st_reg;
    imcab_state_t st_next;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Event enables without the global bit, which only gates them
    function automatic logic [31:0] event_bits(input logic [31:0] m);
        event_bits                              = m;
        event_bits[imcab_pkg::IMCAB_BIT_GLOBAL] = 1'b0;
    endfunction

    // Read mux; its result is registered so read data comes from flip-flops
    function automatic logic [31:0] read_word(
        input logic [7:0]  a,
        input logic [31:0] m,
        input logic [31:0] b
    );
        read_word = 32'h0000_0000;
        if (hit(a, imcab_pkg::IMCAB_OFS_MASK_CLEAR)
            || hit(a, imcab_pkg::IMCAB_OFS_MASK_SET)) begin
            read_word = m;
        end
        if (hit(a, imcab_pkg::IMCAB_OFS_COMM_BASE)) begin
            read_word = b & imcab_pkg::IMCAB_MASK_BASE;
        end
    endfunction

    // One clock domain for every check below
    default clocking imcab_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    always_comb begin
        st_next = st_reg;
        if (soft_reset_in) begin
            // (RQ9) software reset disables
            st_next.mask = imcab_pkg::IMCAB_RST_MASK;
            st_next.base = imcab_pkg::IMCAB_RST_BASE;
        end else if (reg_wr_in) begin
            // (RQ16) set-on-one enable write
            if (hit(reg_addr_in, imcab_pkg::IMCAB_OFS_MASK_SET)) begin
                st_next.mask = st_reg.mask
                             | (reg_wdata_in & imcab_pkg::IMCAB_MASK_DEFINED);
            end
            // (RQ1) clear-on-one mask write
            // (RQ2) zeros leave bits
            // (RQ4) same bit position
            // (RQ5) offset 14h word
            // (RQ6) global bit clearable
            // (RQ7) owner bit clearable
            // (RQ8) event bits clearable
            if (hit(reg_addr_in, imcab_pkg::IMCAB_OFS_MASK_CLEAR)) begin
                st_next.mask = st_reg.mask
                             & ~(reg_wdata_in & imcab_pkg::IMCAB_MASK_DEFINED);
            end
            // (RQ10) base write bits 31..8
            // (RQ11) holds shared base
            // (RQ17) reserved writes dropped
            if (hit(reg_addr_in, imcab_pkg::IMCAB_OFS_COMM_BASE)) begin
                st_next.base = reg_wdata_in & imcab_pkg::IMCAB_MASK_BASE;
            end
        end
        // (RQ15) gated interrupt request
        st_next.irq = st_next.mask[imcab_pkg::IMCAB_BIT_GLOBAL]
                    & (|(interrupt_event_flags_in & event_bits(st_next.mask)));
        // (RQ3) clear reads live enables
        // (RQ12) low byte reads zero
        st_next.rdata = read_word(reg_addr_in, st_next.mask, st_next.base);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            // (RQ9) hardware reset disables
            st_reg.mask <= imcab_pkg::IMCAB_RST_MASK;
            st_reg.base <= imcab_pkg::IMCAB_RST_BASE;
            st_reg.rdata <= 32'h0000_0000;
            st_reg.irq   <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out               = st_reg.rdata;
    assign irq_request_out             = st_reg.irq;
    assign interrupt_mask_register_out = st_reg.mask;
    // (RQ14) base drives fetch address
    assign comm_area_base_out          = st_reg.base;

    // Mask clear and set writes
    a_clear_takes_effect: assert property ( // RQ1
        (reg_wr_in && !soft_reset_in && reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_CLEAR)
        |=> ((st_reg.mask & $past(reg_wdata_in) & imcab_pkg::IMCAB_MASK_DEFINED)
             == 32'h0000_0000)
    ) else $error("mask clear did not clear");

    a_clear_zero_keeps: assert property ( // RQ2
        (reg_wr_in && !soft_reset_in && reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_CLEAR)
        |=> ((st_reg.mask & ~$past(reg_wdata_in))
             == ($past(st_reg.mask) & ~$past(reg_wdata_in)))
    ) else $error("mask clear touched zero bits");

    a_global_clear: assert property ( // RQ6
        (reg_wr_in && !soft_reset_in && reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_CLEAR
         && reg_wdata_in[imcab_pkg::IMCAB_BIT_GLOBAL])
        |=> (!st_reg.mask[imcab_pkg::IMCAB_BIT_GLOBAL] && !irq_request_out)
    ) else $error("global clear left irq enabled");

    a_set_takes_effect: assert property ( // RQ16
        (reg_wr_in && !soft_reset_in && reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_SET)
        |=> ((st_reg.mask & $past(reg_wdata_in) & imcab_pkg::IMCAB_MASK_DEFINED)
             == ($past(reg_wdata_in) & imcab_pkg::IMCAB_MASK_DEFINED))
    ) else $error("enable set failed");

    a_set_zero_keeps: assert property ( // RQ16
        (reg_wr_in && !soft_reset_in && reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_SET)
        |=> ((st_reg.mask & ~$past(reg_wdata_in))
             == ($past(st_reg.mask) & ~$past(reg_wdata_in)))
    ) else $error("enable set touched zero bits");

    a_mask_hold: assert property ( // RQ2
        (!(reg_wr_in && (reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_SET
                         || reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_CLEAR))
         && !soft_reset_in) |=> $stable(st_reg.mask)
    ) else $error("enables changed without a write");

    a_soft_reset_off: assert property ( // RQ9
        soft_reset_in |=> (st_reg.mask == imcab_pkg::IMCAB_RST_MASK
                           && comm_area_base_out == imcab_pkg::IMCAB_RST_BASE
                           && !irq_request_out)
    ) else $error("soft reset left enables");

    a_reserved_zero: assert property ( // RQ17
        ((st_reg.mask & ~imcab_pkg::IMCAB_MASK_DEFINED) == 32'h0000_0000)
    ) else $error("reserved enable bit set");

    // Shared area base
    a_base_write_held: assert property ( // RQ10
        (reg_wr_in && !soft_reset_in && reg_addr_in == imcab_pkg::IMCAB_OFS_COMM_BASE)
        |=> (comm_area_base_out[31:8] == $past(reg_wdata_in[31:8]))
    ) else $error("base write lost");

    a_base_hold: assert property ( // RQ11
        (!(reg_wr_in && reg_addr_in == imcab_pkg::IMCAB_OFS_COMM_BASE) && !soft_reset_in)
        |=> $stable(comm_area_base_out)
    ) else $error("base changed without a write");

    a_base_low_clear: assert property ( // RQ12
        (comm_area_base_out[7:0] == 8'h00)
    ) else $error("base low byte held ones");

    // Registered read port
    a_clear_read_live: assert property ( // RQ3
        (reg_addr_in == imcab_pkg::IMCAB_OFS_MASK_CLEAR)
        |=> (reg_rdata_out == st_reg.mask)
    ) else $error("clear read not live enable");

    a_base_low_zero: assert property ( // RQ12
        (reg_addr_in == imcab_pkg::IMCAB_OFS_COMM_BASE)
        |=> (reg_rdata_out == {comm_area_base_out[31:8], 8'h00})
    ) else $error("base read wrong or low byte not zero");

    a_unmapped_zero: assert property ( // RQ17
        (reg_addr_in != imcab_pkg::IMCAB_OFS_MASK_SET
         && reg_addr_in != imcab_pkg::IMCAB_OFS_MASK_CLEAR
         && reg_addr_in != imcab_pkg::IMCAB_OFS_COMM_BASE)
        |=> (reg_rdata_out == 32'h0000_0000)
    ) else $error("unmapped read not zero");

    // Interrupt request
    a_irq_needs_global: assert property ( // RQ15
        irq_request_out |-> st_reg.mask[imcab_pkg::IMCAB_BIT_GLOBAL]
    ) else $error("irq without global enable");

    a_irq_exact: assert property ( // RQ15
        irq_request_out == (st_reg.mask[imcab_pkg::IMCAB_BIT_GLOBAL]
            && (|($past(interrupt_event_flags_in) & st_reg.mask
                  & ~(32'h0000_0001 << imcab_pkg::IMCAB_BIT_GLOBAL))))
    ) else $error("irq request does not follow enables");

    // Main scenarios
    c_clear_global: cover property (
        irq_request_out ##1 !st_reg.mask[imcab_pkg::IMCAB_BIT_GLOBAL]);
    c_irq_raised: cover property (!irq_request_out ##1 irq_request_out);
    c_base_probe: cover property (comm_area_base_out == imcab_pkg::IMCAB_MASK_BASE);
    c_soft_reset_clear: cover property (soft_reset_in && st_reg.mask != 32'h0000_0000);

endmodule // imcab_regs

// ==== sim/imcab_host_model.sv ====
// Host driver model for the register port.
// Assumes the bench owns the clock; requests change at the falling edge.
`timescale 1ns/100ps
module imcab_host_model (
    // Clock
    input  wire logic        sys_clk_in,
    // Register port
    output logic      [7:0]  reg_addr_out,
    output logic             reg_wr_out,
    output logic      [31:0] reg_wdata_out,
    input  wire logic [31:0] reg_rdata_in
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 32'h0000_0000;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge sys_clk_in);
        reg_addr_out = a;
        reg_wr_out = 1'b1;
        reg_wdata_out = d;
        @(negedge sys_clk_in);
        reg_wr_out = 1'b0;
        // Released data never keeps its last value
        reg_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge sys_clk_in);
        reg_addr_out = a;
        // Read data is registered: take it one clock after the address
        @(negedge sys_clk_in);
        d = reg_rdata_in;
    endtask
    task automatic probe(output int z);
        logic [31:0] v;
        wr(imcab_pkg::IMCAB_OFS_COMM_BASE, 32'hFFFF_FFFF);
        rd(imcab_pkg::IMCAB_OFS_COMM_BASE, v);
        z = 0;
        while (z < 32 && !v[z]) z++;
    endtask
endmodule // imcab_host_model

// ==== sim/irq_mask_clear_and_comm_area_base_bench.sv ====
// Bench for the mask clear and shared area base registers.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module irq_mask_clear_and_comm_area_base_bench;
    logic        sys_clk_in, rst_b_in, soft_reset_in, reg_wr_in, irq_request_out;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, interrupt_event_flags_in, mask_out, base_out;
    logic [31:0] lfsr, m_e, b_e, v;
    int          error_cnt, tests_run, z;
    imcab_regs dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .soft_reset_in(soft_reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .interrupt_event_flags_in(interrupt_event_flags_in), .irq_request_out(irq_request_out),
        .interrupt_mask_register_out(mask_out), .comm_area_base_out(base_out));
    imcab_host_model host_u (.sys_clk_in(sys_clk_in), .reg_addr_out(reg_addr_in),
        .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check_all();
        host_u.rd(imcab_pkg::IMCAB_OFS_MASK_CLEAR, v);
        `CHK("clear_read", m_e, v)
        `CHK("mask", m_e, mask_out)
        host_u.rd(imcab_pkg::IMCAB_OFS_COMM_BASE, v);
        `CHK("base_read", b_e, v)
        `CHK("base", b_e, base_out)
        `CHK("irq", m_e[31] && |(m_e & interrupt_event_flags_in & 32'h7FFF_FFFF), irq_request_out)
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        rst_b_in = 1'b0;
        soft_reset_in = 1'b0;
        interrupt_event_flags_in = 32'h0000_0000;
        lfsr = 32'h0000_aff6;
        m_e = 32'h0000_0000;
        b_e = 32'h0000_0000;
        repeat (20) @(posedge sys_clk_in);
        @(negedge sys_clk_in) rst_b_in = 1'b1;
        check_all();
        for (int i = 31; i >= 0; i--) begin
            interrupt_event_flags_in = 32'hFFFF_FFFF;
            host_u.wr(imcab_pkg::IMCAB_OFS_MASK_SET, 32'hFFFF_FFFF);
            m_e = imcab_pkg::IMCAB_MASK_DEFINED;
            host_u.wr(imcab_pkg::IMCAB_OFS_MASK_CLEAR, 32'h0000_0001 << i);
            m_e[i] = 1'b0;
            check_all();
        end
        repeat (60) begin
            lfsr = nxt(lfsr);
            interrupt_event_flags_in = {lfsr[15:0], lfsr[31:16]};
            host_u.wr({4'h1, lfsr[1:0], 2'b00}, lfsr);
            case (lfsr[1:0])
                2'd0: m_e = m_e | (lfsr & imcab_pkg::IMCAB_MASK_DEFINED);
                2'd1: m_e = m_e & ~lfsr;
                2'd2: b_e = lfsr & imcab_pkg::IMCAB_MASK_BASE;
                default: ;
            endcase
            check_all();
        end
        host_u.rd(8'h1C, v);
        `CHK("unmapped", 32'h0000_0000, v)
        @(negedge sys_clk_in) soft_reset_in = 1'b1;
        @(negedge sys_clk_in) soft_reset_in = 1'b0;
        m_e = 32'h0000_0000;
        b_e = 32'h0000_0000;
        check_all();
        host_u.probe(z);
        `CHK("align", 8, z)
        tally_and_finish();
    end
endmodule // irq_mask_clear_and_comm_area_base_bench
